// *** rtl/ivu_map.svh ***
`ifndef IVU_MAP_SVH
`define IVU_MAP_SVH
`define IVU_RESET_VEC_LO 24'h000000
`define IVU_RESET_VEC_HI 24'h000001
`define IVU_DIVZ_OFS 8'h02
`define IVU_TOP_OFS 8'h04
`define IVU_TABLE_SIZE 256
`define IVU_NUM_EXT 8
`define IVU_NUM_PERIPH 4
`define IVU_CH_BITS 2
`endif

// *** rtl/ivu_pkg.sv ***
package ivu_pkg;
  typedef enum logic [2:0] {
    IVU_IDLE = 3'b000,
    IVU_PUSH = 3'b001,
    IVU_FETCH_LO = 3'b010,
    IVU_FETCH_HI = 3'b011,
    IVU_JUMP = 3'b100
  } ivu_state_t;
  typedef enum logic [1:0] {
    IVU_SRC_RESET = 2'b00,
    IVU_SRC_TOP = 2'b01,
    IVU_SRC_DIVZ = 2'b10,
    IVU_SRC_VEC = 2'b11
  } ivu_src_t;
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } ivu_mem_req_t;
  typedef struct packed {
    logic valid;
    logic [15:0] pc;
    logic [7:0] seg;
    logic push_flags;
    logic iret_needed;
  } ivu_jump_t;
endpackage

// *** rtl/ivu_edge_det.sv ***
`timescale 1ns/1ps
// Synchronised, edge-selectable detector for one external interrupt pin
module ivu_edge_det (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic rising_in,
  output logic pulse_out
);
  logic sync1;
  logic sync2;
  logic last;
  logic pulse;
  logic next_pulse;
  always_comb begin
    next_pulse = rising_in ? (sync2 & ~last) : (~sync2 & last);
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      last <= sync2;
      pulse <= next_pulse;
    end
  end
  assign pulse_out = pulse;
endmodule

// *** rtl/ivu_top.sv ***
`timescale 1ns/1ps
`include "ivu_map.svh"
// Summary of operation
// - Vector table in first 256 segment bytes
// - Reset start address from bytes 0,1
// - Top-level vector at segment offsets 4,5
// - Acknowledged peripheral presents its vector index
// - Upper bits software base, low bits hardware
// - Shared register gives distinct entry per channel
// - Divide-zero vector at code segment 2,3
// - Divide-zero trap does not push flags
// - Eight external inputs, selectable trigger edge
// - Top channel from NMI pin or watchdog
// - Valid enabled request saves status, vectors
module ivu_top (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] ext_pin_in,
  input wire logic [7:0] ext_rising_in,
  input wire logic nmi_pin_in,
  input wire logic top_sel_wdt_in,
  input wire logic wdt_event_in,
  input wire logic divz_trap_in,
  input wire logic int_enable_in,
  input wire logic prio_ok_in,
  input wire logic [3:0] periph_req_in,
  input wire logic [7:0] periph_base_in [4],
  input wire logic [1:0] periph_chan_in [4],
  input wire logic [7:0] interrupt_segment_register_in,
  input wire logic [7:0] code_segment_register_in,
  input wire logic mem_ready_in,
  input wire logic [7:0] mem_rdata_in,
  output ivu_pkg::ivu_mem_req_t mem_out,
  output ivu_pkg::ivu_jump_t jump_out,
  output logic save_status_out,
  output logic [7:0] ext_pending_out,
  output logic [7:0] vector_index_register_out,
  output logic busy_out
);
  logic [7:0] ext_pulse;
  logic nmi_s1;
  logic nmi_s2;
  logic nmi_last;
  logic top_event;
  ivu_pkg::ivu_state_t state;
  ivu_pkg::ivu_state_t next_state;
  ivu_pkg::ivu_src_t src;
  ivu_pkg::ivu_src_t next_src;
  logic [7:0] seg;
  logic [7:0] next_seg;
  logic [7:0] vec;
  logic [7:0] next_vec;
  logic [7:0] lo;
  logic [7:0] next_lo;
  logic [7:0] pend;
  logic [7:0] next_pend;
  logic top_pend;
  logic next_top_pend;
  logic boot_done;
  logic next_boot_done;
  ivu_pkg::ivu_mem_req_t mem;
  ivu_pkg::ivu_mem_req_t next_mem;
  ivu_pkg::ivu_jump_t jump;
  ivu_pkg::ivu_jump_t next_jump;
  logic save;
  logic next_save;
  logic [7:0] vir;
  logic [7:0] next_vir;
  logic busy;
  logic next_busy;
  logic [2:0] ext_idx;
  logic ext_any;
  logic [1:0] per_idx;
  logic per_any;
  genvar g;
  generate
    for (g = 0; g < `IVU_NUM_EXT; g++) begin : g_ext
      ivu_edge_det u_det (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in(ext_pin_in[g]),
        .rising_in(ext_rising_in[g]),
        .pulse_out(ext_pulse[g])
      );
    end
  endgenerate
  // Pseudo-NMI pin is falling-edge sensitive, watchdog is a same-clock pulse
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_last <= 1'b0;
    end else begin
      nmi_s1 <= nmi_pin_in;
      nmi_s2 <= nmi_s1;
      nmi_last <= nmi_s2;
    end
  end
  assign top_event = top_sel_wdt_in ? wdt_event_in : (nmi_last & ~nmi_s2);
  always_comb begin
    ext_idx = 3'h0;
    ext_any = 1'b0;
    for (int i = `IVU_NUM_EXT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        ext_idx = i[2:0];
        ext_any = 1'b1;
      end
    end
    per_idx = 2'h0;
    per_any = 1'b0;
    for (int i = `IVU_NUM_PERIPH - 1; i >= 0; i--) begin
      if (periph_req_in[i]) begin
        per_idx = i[1:0];
        per_any = 1'b1;
      end
    end
  end
  always_comb begin
    next_state = state;
    next_src = src;
    next_seg = seg;
    next_vec = vec;
    next_lo = lo;
    next_boot_done = boot_done;
    next_mem = '0;
    next_jump = '0;
    next_save = 1'b0;
    next_vir = vir;
    next_pend = pend | ext_pulse;
    next_top_pend = top_pend | top_event;
    case (state)
      ivu_pkg::IVU_IDLE: begin
        if (!boot_done) begin
          next_src = ivu_pkg::IVU_SRC_RESET;
          next_seg = 8'h00;
          next_vec = 8'(`IVU_RESET_VEC_LO);
          next_state = ivu_pkg::IVU_FETCH_LO;
        end else if (divz_trap_in) begin
          next_src = ivu_pkg::IVU_SRC_DIVZ;
          next_seg = code_segment_register_in;
          next_vec = `IVU_DIVZ_OFS;
          next_state = ivu_pkg::IVU_FETCH_LO;
        end else if (top_pend && prio_ok_in) begin
          // Top level ignores the global enable, being pseudo non-maskable
          next_top_pend = top_event;
          next_src = ivu_pkg::IVU_SRC_TOP;
          next_seg = interrupt_segment_register_in;
          next_vec = `IVU_TOP_OFS;
          next_state = ivu_pkg::IVU_PUSH;
        end else if (int_enable_in && prio_ok_in && per_any) begin
          next_src = ivu_pkg::IVU_SRC_VEC;
          next_seg = interrupt_segment_register_in;
          next_vec = {periph_base_in[per_idx][7:`IVU_CH_BITS],
                      periph_chan_in[per_idx]};
          next_vir = next_vec;
          next_state = ivu_pkg::IVU_PUSH;
        end else if (int_enable_in && prio_ok_in && ext_any) begin
          // Pins pack from offset 0, so software keeps pin 2 off the top entry
          next_pend[ext_idx] = ext_pulse[ext_idx]; // Set wins over clear
          next_src = ivu_pkg::IVU_SRC_VEC;
          next_seg = interrupt_segment_register_in;
          next_vec = {5'h00, ext_idx} << 1;
          next_vir = next_vec;
          next_state = ivu_pkg::IVU_PUSH;
        end
      end
      ivu_pkg::IVU_PUSH: begin
        next_save = 1'b1;
        next_state = ivu_pkg::IVU_FETCH_LO;
      end
      ivu_pkg::IVU_FETCH_LO: begin
        next_mem.req = 1'b1;
        next_mem.addr = {seg, 8'h00, vec};
        if (mem.req && mem_ready_in) begin
          next_lo = mem_rdata_in;
          next_mem.addr = {seg, 8'h00, vec + 8'h01};
          next_state = ivu_pkg::IVU_FETCH_HI;
        end
      end
      ivu_pkg::IVU_FETCH_HI: begin
        next_mem.req = 1'b1;
        next_mem.addr = {seg, 8'h00, vec + 8'h01};
        if (mem.req && mem_ready_in) begin
          next_mem = '0;
          next_jump.valid = 1'b1;
          next_jump.pc = {mem_rdata_in, lo};
          next_jump.seg = seg;
          next_jump.push_flags = (src != ivu_pkg::IVU_SRC_DIVZ) &&
                                 (src != ivu_pkg::IVU_SRC_RESET);
          next_jump.iret_needed = next_jump.push_flags;
          next_boot_done = 1'b1;
          next_state = ivu_pkg::IVU_JUMP;
        end
      end
      ivu_pkg::IVU_JUMP: begin
        next_state = ivu_pkg::IVU_IDLE;
      end
      default: begin
        next_state = ivu_pkg::IVU_IDLE;
      end
    endcase
    // Registered idle test keeps every top output on a flop
    next_busy = (next_state != ivu_pkg::IVU_IDLE);
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= ivu_pkg::IVU_IDLE;
      src <= ivu_pkg::IVU_SRC_RESET;
      seg <= 8'h00;
      vec <= 8'h00;
      lo <= 8'h00;
      pend <= 8'h00;
      top_pend <= 1'b0;
      boot_done <= 1'b0;
      mem <= '0;
      jump <= '0;
      save <= 1'b0;
      vir <= 8'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      src <= next_src;
      seg <= next_seg;
      vec <= next_vec;
      lo <= next_lo;
      pend <= next_pend;
      top_pend <= next_top_pend;
      boot_done <= next_boot_done;
      mem <= next_mem;
      jump <= next_jump;
      save <= next_save;
      vir <= next_vir;
      busy <= next_busy;
    end
  end
  assign mem_out = mem;
  assign jump_out = jump;
  assign save_status_out = save;
  assign ext_pending_out = pend;
  assign vector_index_register_out = vir;
  assign busy_out = busy;

  sequence s_fetch_done;
    mem.req && mem_ready_in ##1 (state == ivu_pkg::IVU_FETCH_HI);
  endsequence

  sequence s_divz_taken;
    state == ivu_pkg::IVU_IDLE && boot_done && divz_trap_in;
  endsequence

  a_reset_fetch_addr: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (mem.req && src == ivu_pkg::IVU_SRC_RESET) |-> mem.addr[23:1] == 23'h0)
    else $error("reset vector fetch outside bytes 0 and 1");
  a_boot_first: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state == ivu_pkg::IVU_IDLE && !boot_done) |=>
    (state == ivu_pkg::IVU_FETCH_LO && src == ivu_pkg::IVU_SRC_RESET && seg == 8'h00))
    else $error("reset vector not fetched first");
  a_top_fetch_addr: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (mem.req && src == ivu_pkg::IVU_SRC_TOP) |->
    (mem.addr[7:0] == 8'h04 || mem.addr[7:0] == 8'h05))
    else $error("top level vector address wrong");
  a_top_ignores_enable: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state == ivu_pkg::IVU_IDLE && boot_done && !divz_trap_in && top_pend && prio_ok_in &&
     !int_enable_in) |=> (state == ivu_pkg::IVU_PUSH && src == ivu_pkg::IVU_SRC_TOP))
    else $error("top level request not taken while masked");
  a_divz_fetch_addr: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (mem.req && src == ivu_pkg::IVU_SRC_DIVZ) |->
    (mem.addr[7:0] == 8'h02 || mem.addr[7:0] == 8'h03))
    else $error("divide by zero vector address wrong");
  a_divz_skip_save: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_divz_taken |=>
    (state == ivu_pkg::IVU_FETCH_LO && src == ivu_pkg::IVU_SRC_DIVZ && !save))
    else $error("divide by zero trap saved status");
  a_table_window: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mem.req |-> mem.addr[15:8] == 8'h00)
    else $error("vector fetch outside first 256 bytes");
  a_jump_seg: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    jump.valid |-> jump.seg == seg)
    else $error("jump segment differs from table segment");
  a_divz_no_flags: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (jump.valid && src == ivu_pkg::IVU_SRC_DIVZ) |-> !jump.push_flags)
    else $error("divide by zero pushed flags");
  a_iret_flags: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    jump.valid |-> jump.iret_needed == jump.push_flags)
    else $error("return kind does not follow flag push");
  a_jump_one_cycle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    jump.valid |=> !jump.valid)
    else $error("jump strobe longer than one cycle");
  a_save_before_fetch: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state == ivu_pkg::IVU_PUSH) |=> save && state == ivu_pkg::IVU_FETCH_LO)
    else $error("status not saved before vector fetch");
  a_hi_byte_next: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_fetch_done |-> mem.addr == {seg, 8'h00, vec + 8'h01})
    else $error("high byte not at next address");
  // A stalled fetch must keep its address until memory answers
  a_mem_req_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (mem.req && !mem_ready_in) |=> (mem.req && $stable(mem.addr)))
    else $error("stalled fetch dropped or moved");
  a_vec_low_bits: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state == ivu_pkg::IVU_IDLE && next_state == ivu_pkg::IVU_PUSH && per_any &&
     !top_pend && !divz_trap_in && int_enable_in) |=>
    vir[1:0] == $past(periph_chan_in[per_idx]))
    else $error("vector low bits not from channel");
  a_ext_vec_even: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state == ivu_pkg::IVU_IDLE && next_state == ivu_pkg::IVU_PUSH &&
     next_src == ivu_pkg::IVU_SRC_VEC && !per_any) |=>
    (vir[7:4] == 4'h0 && vir[0] == 1'b0))
    else $error("pin vector outside its entry range");
endmodule

// *** dv/ivu_mem_model.sv ***
`timescale 1ns/1ps
// Byte memory that answers each fetch after wait_in idle cycles
module ivu_mem_model (
  input wire logic clock_in,
  input wire ivu_pkg::ivu_mem_req_t mem_in,
  input wire logic [1:0] wait_in,
  output logic mem_ready_out,
  output logic [7:0] mem_rdata_out
);
  int cnt = 0;
  initial begin
    mem_ready_out = 1'b0;
    mem_rdata_out = 8'h00;
  end
  always @(posedge clock_in) begin
    mem_ready_out <= 1'b0;
    // Released bus keeps toggling so a late sample cannot match by luck
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_in.req === 1'b1 && !mem_ready_out) begin
      if (cnt >= wait_in) begin
        mem_ready_out <= 1'b1;
        mem_rdata_out <= mem_in.addr[7:0] ^ mem_in.addr[23:16] ^ 8'h5A;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clock_in, rst_n_in, nmi_pin_in, top_sel, wdt_event_in, divz_trap_in;
  logic int_enable_in, prio_ok_in, mem_ready_in, r;
  logic [7:0] ext_pin_in, ext_rising_in, interrupt_segment_register, code_segment_register, mem_rdata_in, v;
  logic [7:0] vir, pend;
  logic [3:0] periph_req;
  logic [7:0] base [4];
  logic [1:0] chan [4];
  logic [1:0] wt;
  logic save, busy_out;
  ivu_pkg::ivu_mem_req_t mem_out;
  ivu_pkg::ivu_jump_t jump_out;
  logic [23:0] got [$];
  int saves = 0;
  int miscompares = 0;
  int check_count = 0;
  ivu_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ext_pin_in(ext_pin_in),
    .ext_rising_in(ext_rising_in), .nmi_pin_in(nmi_pin_in), .top_sel_wdt_in(top_sel),
    .wdt_event_in(wdt_event_in), .divz_trap_in(divz_trap_in),
    .int_enable_in(int_enable_in), .prio_ok_in(prio_ok_in), .periph_req_in(periph_req),
    .periph_base_in(base), .periph_chan_in(chan), .interrupt_segment_register_in(interrupt_segment_register),
    .code_segment_register_in(code_segment_register), .mem_ready_in(mem_ready_in),
    .mem_rdata_in(mem_rdata_in), .mem_out(mem_out), .jump_out(jump_out),
    .save_status_out(save), .ext_pending_out(pend), .vector_index_register_out(vir),
    .busy_out(busy_out));
  ivu_mem_model mem (.clock_in(clock_in), .mem_in(mem_out), .wait_in(wt),
    .mem_ready_out(mem_ready_in), .mem_rdata_out(mem_rdata_in));
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (save === 1'b1) saves++;
    if (mem_out.req === 1'b1 && mem_ready_in === 1'b1) got.push_back(mem_out.addr);
  end
  function automatic logic [7:0] d(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits for one vector fetch, dropping level requests once taken
  task automatic serve(input logic [23:0] a, input logic intr);
    int n;
    int s0;
    s0 = saves;
    n = 0;
    got.delete();
    wt = 2'($urandom);
    do begin
      @(negedge clock_in);
      wdt_event_in = 1'b0;
      if (busy_out === 1'b1) begin
        divz_trap_in = 1'b0;
        periph_req = 4'h0;
      end
      n++;
    end while (jump_out.valid !== 1'b1 && n < 300);
    if (n >= 300) begin
      miscompares++;
      tally_and_finish();
    end else begin
      chk(24'(got.size()), 24'h2);
      chk(got[0], a);
      chk(got[1], a + 24'h1);
      chk(24'(jump_out.pc), {8'h00, d(a + 24'h1), d(a)});
      if (a != 24'h0) begin
        chk(24'(jump_out.seg), 24'(a[23:16]));
        chk(24'(jump_out.push_flags), 24'(intr));
        chk(24'(jump_out.iret_needed), 24'(intr));
        chk(24'(saves - s0), 24'(intr));
      end
    end
  endtask
  initial begin
    void'($urandom(65935));
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    ext_pin_in = 8'hFF;
    ext_rising_in = 8'h00;
    nmi_pin_in = 1'b1;
    top_sel = 1'b0;
    wdt_event_in = 1'b0;
    divz_trap_in = 1'b0;
    int_enable_in = 1'b0;
    prio_ok_in = 1'b1;
    periph_req = 4'h0;
    wt = 2'h0;
    interrupt_segment_register = 8'($urandom);
    code_segment_register = 8'($urandom);
    for (int i = 0; i < 4; i++) begin
      base[i] = 8'($urandom);
      // Keep entry FFh unused so both bytes of an entry stay in the table
      if (base[i][7:2] == 6'h3F) base[i][7] = 1'b0;
      chan[i] = 2'h0;
    end
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    serve(24'h000000, 1'b0);
    divz_trap_in = 1'b1;
    serve({code_segment_register, 8'h00, 8'h02}, 1'b0);
    // Top channel must be taken with interrupts disabled
    nmi_pin_in = 1'b0;
    serve({interrupt_segment_register, 8'h00, 8'h04}, 1'b1);
    nmi_pin_in = 1'b1;
    top_sel = 1'b1;
    wdt_event_in = 1'b1;
    serve({interrupt_segment_register, 8'h00, 8'h04}, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = 1'($urandom);
      ext_rising_in[i] = r;
      ext_pin_in[i] = ~r;
      repeat (4) @(negedge clock_in);
      ext_pin_in[i] = r;
      repeat (8) @(negedge clock_in);
      chk(24'(pend[i]), 24'h1);
      chk(24'(busy_out), 24'h0);
      prio_ok_in = 1'b0;
      int_enable_in = 1'b1;
      repeat (4) @(negedge clock_in);
      chk(24'(busy_out), 24'h0);
      prio_ok_in = 1'b1;
      serve({interrupt_segment_register, 8'h00, 8'(i * 2)}, 1'b1);
      chk(24'(pend[i]), 24'h0);
      int_enable_in = 1'b0;
    end
    int_enable_in = 1'b1;
    // Two channels per peripheral share one base
    for (int i = 0; i < 8; i++) begin
      chan[i / 2] = 2'(i);
      periph_req = 4'(1 << (i / 2));
      v = {base[i / 2][7:2], 2'(i)};
      serve({interrupt_segment_register, 8'h00, v}, 1'b1);
      chk(24'(vir), 24'(v));
    end
    tally_and_finish();
  end
endmodule
